// File: sdwl_consts.svh
// constants for the serial dac word loader
`ifndef SDWL_CONSTS_SVH
`define SDWL_CONSTS_SVH
`define SDWL_WORD_BITS 16
`define SDWL_CODE_BITS 12
`define SDWL_SPEED_BIT 14
`define SDWL_POWER_BIT 13
`define SDWL_BIT_CNT_LAST 5'h10
`define SDWL_RST_CODE 12'h000
`define SDWL_RST_SPEED 1'b0
`define SDWL_RST_POWER 1'b0
`endif

// File: sdwl_pkg.sv
// types for the serial dac word loader
package sdwl_pkg;
	typedef enum logic [2:0] {
		SDWL_IDLE = 3'b001,
		SDWL_SHIFT = 3'b010,
		SDWL_DONE = 3'b100
	} sdwl_state_t;

	typedef struct packed {
		logic cs_n;
		logic frame_sync;
		logic sclk;
		logic din;
	} sdwl_pins_t;

	typedef struct packed {
		logic speed_select;
		logic power_down_request;
		logic [11:0] code;
	} sdwl_dac_t;

	typedef struct packed {
		sdwl_pins_t sync1;
		sdwl_pins_t sync2;
		sdwl_pins_t prev;
		sdwl_state_t state;
		logic [15:0] shift;
		logic [4:0] bit_cnt;
		sdwl_dac_t dac;
		logic update;
	} sdwl_regs_t;
endpackage

// File: sdwl_loader.sv
// serial word loader that feeds a 12-bit dac with code and control
`timescale 1ns/1ps
`include "sdwl_consts.svh"

module sdwl_loader
	import sdwl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic frame_sync,
	input wire logic sclk,
	input wire logic din,
	output logic [11:0] dac_code,
	output logic speed_select,
	output logic power_down_request,
	output logic dac_update
);

	// ****************************************
	// state
	// ****************************************
	sdwl_regs_t s_reg;
	sdwl_regs_t s_next;
	logic sclk_fall;
	logic fs_fall;
	logic fs_rise;
	logic selected;

	// every pin passes sync1 and sync2; prev holds the sync2 value one cycle older,
	// so an edge on a pin is seen two clk_sys cycles after it happens.
	// din is read from sync2 in the same cycle as the sclk fall, which keeps both
	// on the same delay; the host must hold din for that long around the fall.
	assign selected = ~s_reg.sync2.cs_n;
	assign sclk_fall = s_reg.prev.sclk & ~s_reg.sync2.sclk;
	assign fs_fall = s_reg.prev.frame_sync & ~s_reg.sync2.frame_sync;
	assign fs_rise = ~s_reg.prev.frame_sync & s_reg.sync2.frame_sync;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_next = s_reg;
		s_next.sync1 = '{
			cs_n: cs_n,
			frame_sync: frame_sync,
			sclk: sclk,
			din: din
		};
		s_next.sync2 = s_reg.sync1;
		s_next.prev = s_reg.sync2;
		s_next.update = 1'b0;
		case (s_reg.state)
			SDWL_IDLE: begin
				if (selected && fs_fall) begin
					s_next.state = SDWL_SHIFT;
					s_next.bit_cnt = 5'h00;
				end
			end
			SDWL_SHIFT: begin
				if (!selected) begin
					s_next.state = SDWL_IDLE;
				end else if (fs_rise) begin
					s_next.dac.speed_select = s_reg.shift[`SDWL_SPEED_BIT];
					s_next.dac.power_down_request = s_reg.shift[`SDWL_POWER_BIT];
					s_next.dac.code = s_reg.shift[`SDWL_CODE_BITS-1:0];
					s_next.update = 1'b1;
					s_next.state = SDWL_IDLE;
				end else if (sclk_fall) begin
					s_next.shift = {s_reg.shift[`SDWL_WORD_BITS-2:0], s_reg.sync2.din};
					s_next.bit_cnt = s_reg.bit_cnt + 5'h01;
					if (s_reg.bit_cnt + 5'h01 == `SDWL_BIT_CNT_LAST) begin
						s_next.state = SDWL_DONE;
					end
				end
			end
			SDWL_DONE: begin
				// word splits into control bits and straight code
				s_next.dac.speed_select = s_reg.shift[`SDWL_SPEED_BIT];
				s_next.dac.power_down_request = s_reg.shift[`SDWL_POWER_BIT];
				s_next.dac.code = s_reg.shift[`SDWL_CODE_BITS-1:0];
				s_next.update = 1'b1;
				s_next.state = SDWL_IDLE;
			end
			default: begin
				s_next.state = SDWL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg <= '0;
			// idle pin levels, so no false edge follows reset
			s_reg.sync1 <= '{
				cs_n: 1'b1,
				frame_sync: 1'b1,
				sclk: 1'b1,
				din: 1'b0
			};
			s_reg.sync2 <= '{
				cs_n: 1'b1,
				frame_sync: 1'b1,
				sclk: 1'b1,
				din: 1'b0
			};
			s_reg.prev <= '{
				cs_n: 1'b1,
				frame_sync: 1'b1,
				sclk: 1'b1,
				din: 1'b0
			};
			s_reg.state <= SDWL_IDLE;
			s_reg.dac <= '{speed_select: `SDWL_RST_SPEED,
				power_down_request: `SDWL_RST_POWER, code: `SDWL_RST_CODE};
		end else begin
			s_reg <= s_next;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign dac_code = s_reg.dac.code;
	assign speed_select = s_reg.dac.speed_select;
	assign power_down_request = s_reg.dac.power_down_request;
	assign dac_update = s_reg.update;

	// ****************************************
	// assertions
	// ****************************************
	// one bit accepted this cycle, and a frame cut short by frame_sync
	logic shift_step;
	logic early_end;

	assign shift_step = s_reg.state == SDWL_SHIFT && selected && !fs_rise && sclk_fall;
	assign early_end = s_reg.state == SDWL_SHIFT && selected && fs_rise;

	a_full_word_update: assert property (@(posedge clk_sys) disable iff (rst)
		(shift_step && s_reg.bit_cnt == 5'h0f)
		|=> ##1 dac_update)
		else $error("no update after sixteen bits");

	a_early_update: assert property (@(posedge clk_sys) disable iff (rst)
		early_end
		|=> dac_update)
		else $error("no update on early frame_sync rise");

	a_code_split: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_DONE)
		|=> dac_code == $past(s_reg.shift[11:0]))
		else $error("code field wrong");

	a_speed_bit: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_DONE)
		|=> speed_select == $past(s_reg.shift[14]))
		else $error("speed bit wrong");

	a_power_bit: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_DONE)
		|=> power_down_request == $past(s_reg.shift[13]))
		else $error("power bit wrong");

	a_deselect_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(!selected && s_reg.state != SDWL_DONE)
		|=> !dac_update && $stable(dac_code))
		else $error("update while deselected");

	a_shift_msb: assert property (@(posedge clk_sys) disable iff (rst)
		shift_step
		|=> s_reg.shift[0] == $past(s_reg.sync2.din))
		else $error("bit not shifted on sclk fall");

	a_frame_start: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_IDLE && selected && fs_fall)
		|=> s_reg.state == SDWL_SHIFT && s_reg.bit_cnt == 5'h00)
		else $error("frame not opened");

	a_reset_vals: assert property (@(posedge clk_sys)
		rst
		|=> dac_code == 12'h000 && !speed_select && !power_down_request)
		else $error("reset values wrong");

	a_reset_state: assert property (@(posedge clk_sys)
		rst
		|=> s_reg.state == SDWL_IDLE && s_reg.shift == 16'h0000 && !dac_update)
		else $error("reset state wrong");

	a_update_pulse: assert property (@(posedge clk_sys) disable iff (rst)
		dac_update
		|=> !dac_update)
		else $error("update pulse longer than one cycle");

	a_update_source: assert property (@(posedge clk_sys) disable iff (rst)
		dac_update
		|-> $past(s_reg.state == SDWL_DONE) || $past(early_end))
		else $error("update without a finished frame");

	a_state_onehot: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1
		|-> $onehot(s_reg.state))
		else $error("state not one-hot");

	a_code_hold: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(dac_code)
		|-> dac_update)
		else $error("code changed without update");

	a_speed_hold: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(speed_select)
		|-> dac_update)
		else $error("speed changed without update");

	a_power_hold: assert property (@(posedge clk_sys) disable iff (rst)
		$changed(power_down_request)
		|-> dac_update)
		else $error("power changed without update");

	a_idle_no_update: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_IDLE)
		|=> !dac_update)
		else $error("update from idle");

	a_idle_shift_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_IDLE)
		|=> $stable(s_reg.shift))
		else $error("shift moved outside a frame");

	a_frame_wait: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_IDLE && !(selected && fs_fall))
		|=> s_reg.state == SDWL_IDLE)
		else $error("frame opened without frame_sync fall");

	a_bit_cnt_max: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1
		|-> s_reg.bit_cnt <= 5'h10)
		else $error("bit count past sixteen");

	a_done_count: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_DONE)
		|-> s_reg.bit_cnt == 5'h10)
		else $error("word done before sixteen bits");

	a_done_single: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_DONE)
		|=> s_reg.state == SDWL_IDLE)
		else $error("done state held");

	a_bit_count_step: assert property (@(posedge clk_sys) disable iff (rst)
		shift_step
		|=> s_reg.bit_cnt == $past(s_reg.bit_cnt) + 5'h01)
		else $error("bit count not advanced");

	a_shift_upward: assert property (@(posedge clk_sys) disable iff (rst)
		shift_step
		|=> s_reg.shift[15:1] == $past(s_reg.shift[14:0]))
		else $error("word not shifted msb first");

	a_no_edge_hold: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_SHIFT && selected && !fs_rise && !sclk_fall)
		|=> $stable(s_reg.shift) && $stable(s_reg.bit_cnt))
		else $error("shift moved without sclk fall");

	a_deselect_abort: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_SHIFT && !selected)
		|=> s_reg.state == SDWL_IDLE && !dac_update)
		else $error("frame kept after deselect");

	a_deselect_idle: assert property (@(posedge clk_sys) disable iff (rst)
		(s_reg.state == SDWL_IDLE && !selected)
		|=> s_reg.state == SDWL_IDLE)
		else $error("frame opened while deselected");

	a_early_code: assert property (@(posedge clk_sys) disable iff (rst)
		early_end
		|=> dac_code == $past(s_reg.shift[11:0]))
		else $error("early code wrong");

	a_speed_early: assert property (@(posedge clk_sys) disable iff (rst)
		early_end
		|=> speed_select == $past(s_reg.shift[14]))
		else $error("early speed bit wrong");

	c_full_frame: cover property (@(posedge clk_sys) s_reg.state == SDWL_DONE);
	c_early_end: cover property (@(posedge clk_sys) early_end);
	c_power_down: cover property (@(posedge clk_sys) dac_update && power_down_request);
	c_fast_mode: cover property (@(posedge clk_sys) dac_update && speed_select);
	c_abort: cover property (@(posedge clk_sys) s_reg.state == SDWL_SHIFT && !selected);
endmodule

// File: sdwl_host_model.sv
// host serial port model that drives the loader pins
`timescale 1ns/1ps
module sdwl_host_model (
	output logic cs_n,
	output logic frame_sync,
	output logic sclk,
	output logic din
);
	initial begin
		cs_n = 1'b1;
		frame_sync = 1'b1;
		sclk = 1'b1;
		din = 1'b0;
	end
	// sends n bits of w msb first; abort raises cs_n mid-frame
	task automatic send(input logic [15:0] w, input int n, input bit abort);
		cs_n = 1'b0;
		#40 frame_sync = 1'b0;
		for (int i = 0; i < n; i++) begin
			#30 din = w[15 - (i % 16)];
			#32.5 sclk = 1'b0;
			#62.5 sclk = 1'b1;
		end
		if (abort) begin
			cs_n = 1'b1;
			repeat (4) #62.5 sclk = ~sclk;
		end else if (n >= 16) begin
			#62.5 sclk = 1'b0;
			#62.5 sclk = 1'b1;
		end
		#20 frame_sync = 1'b1;
		#40 cs_n = 1'b1;
		din = ~din;
	endtask
endmodule

// File: test_serial_dac_word_loader.sv
// self-checking bench for the serial dac word loader
`timescale 1ns/1ps
module test_serial_dac_word_loader;
	import sdwl_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic cs_n, frame_sync, sclk, din, speed_select, power_down_request, dac_update;
	logic [11:0] dac_code;
	logic [13:0] exp_q[$];
	logic [31:0] seed = 32'h29;
	logic [15:0] w;
	logic [15:0] r;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	always #4 clk_sys = ~clk_sys;
	sdwl_host_model host_u (.cs_n(cs_n), .frame_sync(frame_sync), .sclk(sclk), .din(din));
	sdwl_loader dut_u (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .frame_sync(frame_sync),
		.sclk(sclk), .din(din), .dac_code(dac_code), .speed_select(speed_select),
		.power_down_request(power_down_request), .dac_update(dac_update));
	function automatic logic [15:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	task automatic check(input logic [13:0] seen, input logic [13:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// every update is matched against the oldest expectation, or against 14'h3fff when the queue is empty
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end else if (dac_update === 1'b1) begin
			if (exp_q.size() == 0)
				check({speed_select, power_down_request, dac_code}, 14'h3fff);
			else
				check({speed_select, power_down_request, dac_code}, exp_q.pop_front());
		end
	end
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check({speed_select, power_down_request, dac_code}, 14'h0000);
		for (int k = 0; k < 6; k++) begin
			w = xs();
			exp_q.push_back({w[14], w[13], w[11:0]});
			host_u.send(w, 16 + k % 3, 1'b0);
		end
		for (int k = 0; k < 4; k++) begin
			r = xs();
			w = {1'b1, k[1:0], 1'b1, r[11:6], 6'h00};
			exp_q.push_back({w[14], w[13], w[11:0]});
			host_u.send(w, 16, 1'b0);
		end
		w = xs();
		exp_q.push_back({4'h0, w[15:6]});
		host_u.send(w, 10, 1'b0);
		host_u.send(xs(), 9, 1'b1);
		w = xs();
		exp_q.push_back({w[14], w[13], w[11:0]});
		host_u.send(w, 16, 1'b0);
		repeat (50) @(posedge clk_sys);
		check(14'(exp_q.size()), 14'h0000);
		end_sim();
	end
endmodule
